//--- isp_defines.vh
// Constants of the serial programming controller.
`ifndef ISP_DEFINES_VH
`define ISP_DEFINES_VH
`define CLK_MHZ 200
`define SCK_DIV 8'h0f
`define PWRUP_WAIT_US 20000
`define PWRUP_CYC (`PWRUP_WAIT_US * `CLK_MHZ)
`define RST_PULSE_CYC 24'h000040
`define PAGE_WRITE_WAIT_US 4500
`define FUSE_WRITE_WAIT_US 4500
`define EEPROM_WRITE_WAIT_US 9000
`define ERASE_WAIT_US 9000
`define PAGE_WRITE_CYC (`PAGE_WRITE_WAIT_US * `CLK_MHZ)
`define FUSE_WRITE_CYC (`FUSE_WRITE_WAIT_US * `CLK_MHZ)
`define EEPROM_WRITE_CYC (`EEPROM_WRITE_WAIT_US * `CLK_MHZ)
`define ERASE_CYC (`ERASE_WAIT_US * `CLK_MHZ)
`define OP_PROG_EN 8'hac
`define OP_ECHO 8'h53
`define OP_ERASE_B2 8'h80
`define OP_READ_PROG 8'h20
`define OP_LOAD_PAGE 8'h40
`define OP_WRITE_PAGE 8'h4c
`define OP_READ_EE 8'ha0
`define OP_WRITE_EE 8'hc0
`define OP_READ_LOCK 8'h58
`define OP_WRITE_LOCK_B2 8'he0
`define OP_WRITE_FUSE_B2 8'ha0
`define OP_WRITE_FUSEH_B2 8'ha8
`define OP_READ_FUSE 8'h50
`define OP_READ_FUSEH_B2 8'h08
`define OP_READ_SIG 8'h30
`define OP_READ_CAL 8'h38
`define HI_SEL_BIT 3
`define WAIT_NONE 3'h0
`define WAIT_PAGE 3'h1
`define WAIT_EE 3'h2
`define WAIT_FUSE 3'h3
`define WAIT_ERASE 3'h4
`endif

//--- sync2.v
// Two-flop synchroniser for one level from outside the clock domain.
`timescale 1ns/10ps
module sync2 (
  input wire clk_i,
  input wire arst_n_i,
  input wire ce_i,
  input wire d_i,
  output wire q_o
);
  reg s1_r;
  reg s2_r;
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
    end
    else if (ce_i)
    begin
      s1_r <= d_i;
      s2_r <= s1_r;
    end
  end
  assign q_o = s2_r;
endmodule // sync2

//--- wait_timer.v
// Down counter that times the least waits of the programming sequence.
`timescale 1ns/10ps
module wait_timer (
  input wire clk_i,
  input wire arst_n_i,
  input wire ce_i,
  input wire load_i,
  input wire [31:0] count_i,
  output wire busy_o
);
  reg [31:0] cnt_r;
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      cnt_r <= 32'h00000000;
    else if (ce_i)
    begin
      if (load_i)
        cnt_r <= count_i;
      else if (cnt_r != 32'h00000000)
        cnt_r <= cnt_r - 32'h00000001;
    end
  end
  assign busy_o = (cnt_r != 32'h00000000);
endmodule // wait_timer

//--- isp_host.v
// Host controller that drives the serial programming pins of the device.
// Overview of operation
// R1 - Device samples MOSI on SCK rising; host changes MOSI while SCK is low.
// R2 - Device shifts MISO on SCK falling; host samples it on rising edge.
// R3 - Hold reset and SCK low at power-up; pulse reset high with SCK low.
// R4 - Wait at least 20 ms after reset before the program-enable frame.
// R5 - Device echoes 0x53 during third byte of program enable.
// R6 - Always send four bytes; on bad echo pulse reset and retry.
// R7 - Flash written per page: load words by 5 low bits, commit by 7 high.
// R8 - Only reads are issued until a pending write completes.
// R9 - EEPROM byte write auto-erases the location first.
// R10 - Flash page reads 0xFF while busy; polled until value matches.
// R11 - For 0xFF page data wait at least 4.5 ms instead of polling.
// R12 - EEPROM reads 0xFF while busy; 0xFF data waits at least 9.0 ms.
// R13 - Wait 4.5 ms after fuse write and 9.0 ms after chip erase.
// R14 - Program enable is AC 53 xx xx.
// R15 - Chip erase is AC 100x_xxxx xx xx.
// R16 - Program read: H in bit 3 of byte 1, address in bytes 2 and 3.
// R17 - Page load: 0100 H000, word index in 5 low bits, low byte first.
// R18 - Page commit: 4C, high bits in byte 2, low bits in byte 3 top.
// R19 - EEPROM read A0, write C0, nine-bit address, data in byte 4.
// R20 - Lock read 58; lock write AC E0 with six bits in byte 4.
// R21 - Fuse writes AC A0 / AC A8; reads 50 00 and 58 08.
// R22 - Signature read 30, calibration 38, byte select in byte 3.
// R23 - Program enable must succeed before any program or erase command.
// R24 - SCK low and high phases each last more than 3 device clocks.
// R25 - Bytes go MSB first; four bytes make one frame.
`timescale 1ns/10ps
`include "isp_defines.vh"
module isp_host #(
  parameter [31:0] PWRUP_CYC = `PWRUP_CYC,
  parameter [31:0] PAGE_WRITE_CYC = `PAGE_WRITE_CYC,
  parameter [31:0] FUSE_WRITE_CYC = `FUSE_WRITE_CYC,
  parameter [31:0] EEPROM_WRITE_CYC = `EEPROM_WRITE_CYC,
  parameter [31:0] ERASE_CYC = `ERASE_CYC
) (
  input wire clk_i,
  input wire arst_n_i,
  input wire ce_i,
  input wire start_i,
  input wire [7:0] op_i,
  input wire [7:0] b2_i,
  input wire [7:0] b3_i,
  input wire [7:0] b4_i,
  input wire poll_i,
  input wire [2:0] wait_sel_i,
  input wire enter_i,
  input wire leave_i,
  input wire miso_i,
  output reg sck_o,
  output reg mosi_o,
  output reg reset_n_o,
  output reg busy_o,
  output reg done_o,
  output reg [7:0] rdata_o,
  output reg sync_ok_o,
  output reg sync_fail_o
);
  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [3:0] S_OFF = 4'h0;
  localparam [3:0] S_RPULSE = 4'h1;
  localparam [3:0] S_PWAIT = 4'h2;
  localparam [3:0] S_ENFRM = 4'h3;
  localparam [3:0] S_IDLE = 4'h4;
  localparam [3:0] S_FRAME = 4'h5;
  localparam [3:0] S_POLL = 4'h6;
  localparam [3:0] S_TWAIT = 4'h7;

  reg [3:0] state_r;
  reg [31:0] frame_r;
  reg [31:0] cmd_r;
  reg [4:0] bit_r;
  reg [7:0] div_r;
  reg [7:0] shin_r;
  reg [7:0] echo_r;
  reg [2:0] wsel_r;
  reg poll_r;
  reg tload_r;
  reg [31:0] tcnt_r;
  wire miso_s;
  wire tbusy;
  wire is_read;
  wire [31:0] poll_frame;

  // ----------------------------------------------------------------
  // Input synchroniser and least-wait timer
  // ----------------------------------------------------------------
  sync2 u_miso (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .d_i(miso_i),
    .q_o(miso_s)
  );

  wait_timer u_wait (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .load_i(tload_r),
    .count_i(tcnt_r),
    .busy_o(tbusy)
  );

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  // Reads are the codes 0x00 to 0x3f, 0x50 to 0x5f and the EEPROM read.
  assign is_read = (op_i == `OP_READ_EE) || (op_i[7:6] == 2'b00) ||
    (op_i[7:4] == 4'h5); // R8
  // Polling reads the written location back: page or EEPROM read.
  assign poll_frame = (cmd_r[31:24] == `OP_WRITE_EE) ?
    {`OP_READ_EE, cmd_r[23:8], 8'h00} :
    {`OP_READ_PROG, cmd_r[23:8], 8'h00}; // R10 R12

  // ----------------------------------------------------------------
  // Sequencer and serial shifter
  // ----------------------------------------------------------------
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_r <= S_OFF;
      sck_o <= 1'b0;
      mosi_o <= 1'b0;
      reset_n_o <= 1'b0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      rdata_o <= 8'h00;
      sync_ok_o <= 1'b0;
      sync_fail_o <= 1'b0;
      frame_r <= 32'h00000000;
      cmd_r <= 32'h00000000;
      bit_r <= 5'h00;
      div_r <= 8'h00;
      shin_r <= 8'h00;
      echo_r <= 8'h00;
      wsel_r <= `WAIT_NONE;
      poll_r <= 1'b0;
      tload_r <= 1'b0;
      tcnt_r <= 32'h00000000;
    end
    else if (ce_i)
    begin
      tload_r <= 1'b0;
      done_o <= 1'b0;
      case (state_r)
        S_OFF:
        begin
          sck_o <= 1'b0; // R3
          // The reset pin keeps its level here, so a released device runs.
          busy_o <= 1'b0;
          sync_ok_o <= 1'b0;
          if (enter_i)
          begin
            busy_o <= 1'b1;
            reset_n_o <= 1'b1; // R3
            tcnt_r <= {8'h00, `RST_PULSE_CYC};
            tload_r <= 1'b1;
            state_r <= S_RPULSE;
          end
        end
        S_RPULSE:
        begin
          if (!tload_r && !tbusy)
          begin
            reset_n_o <= 1'b0;
            tcnt_r <= PWRUP_CYC; // R4
            tload_r <= 1'b1;
            state_r <= S_PWAIT;
          end
        end
        S_PWAIT:
        begin
          if (!tload_r && !tbusy) // R4
          begin
            frame_r <= {`OP_PROG_EN, `OP_ECHO, 16'h0000}; // R14
            bit_r <= 5'h00;
            div_r <= 8'h00;
            state_r <= S_ENFRM;
          end
        end
        S_ENFRM, S_FRAME, S_POLL:
        begin
          if (div_r == 8'h00 && !sck_o)
            mosi_o <= frame_r[31]; // R1 R25
          if (div_r == `SCK_DIV) // R24
          begin
            div_r <= 8'h00;
            sck_o <= ~sck_o;
            if (!sck_o)
            begin
              shin_r <= {shin_r[6:0], miso_s}; // R2
              frame_r <= {frame_r[30:0], 1'b0};
            end
            else
            begin
              bit_r <= bit_r + 5'h01;
              if (bit_r[2:0] == 3'h7 && bit_r[4:3] == 2'h2)
                echo_r <= shin_r; // R5
              if (bit_r == 5'h1f) // R6
              begin
                rdata_o <= shin_r;
                if (state_r == S_ENFRM)
                begin
                  if (echo_r == `OP_ECHO) // R23
                  begin
                    sync_ok_o <= 1'b1;
                    busy_o <= 1'b0;
                    state_r <= S_IDLE;
                  end
                  else
                  begin
                    sync_fail_o <= 1'b1;
                    reset_n_o <= 1'b1; // R6
                    tcnt_r <= {8'h00, `RST_PULSE_CYC};
                    tload_r <= 1'b1;
                    state_r <= S_RPULSE;
                  end
                end
                else if (state_r == S_POLL)
                begin
                  if (shin_r == cmd_r[7:0]) // R10 R12
                  begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                    state_r <= S_IDLE;
                  end
                  else
                  begin
                    // A mismatch sends the same read again at once.
                    frame_r <= poll_frame;
                    div_r <= 8'h00;
                  end
                end
                else if (wsel_r == `WAIT_NONE)
                begin
                  busy_o <= 1'b0;
                  done_o <= 1'b1;
                  state_r <= S_IDLE;
                end
                else if (poll_r && cmd_r[7:0] != 8'hff)
                begin
                  frame_r <= poll_frame; // R10
                  state_r <= S_POLL;
                end
                else
                begin
                  tload_r <= 1'b1; // R11 R12 R13
                  state_r <= S_TWAIT;
                end
              end
            end
          end
          else
            div_r <= div_r + 8'h01;
        end
        S_TWAIT:
        begin
          // The least wait counts from the end of the write frame.
          if (!tload_r && !tbusy) // R8
          begin
            busy_o <= 1'b0;
            done_o <= 1'b1;
            state_r <= S_IDLE;
          end
        end
        S_IDLE:
        begin
          if (leave_i)
          begin
            reset_n_o <= 1'b1;
            sync_ok_o <= 1'b0;
            state_r <= S_OFF;
          end
          else if (start_i)
          begin
            busy_o <= 1'b1;
            frame_r <= {op_i, b2_i, b3_i, b4_i}; // R15 R16 R17 R18 R19
            cmd_r <= {op_i, b2_i, b3_i, b4_i}; // R20 R21 R22
            poll_r <= poll_i;
            wsel_r <= is_read ? `WAIT_NONE : wait_sel_i; // R7 R9
            case (wait_sel_i)
              `WAIT_PAGE: tcnt_r <= PAGE_WRITE_CYC; // R11
              `WAIT_EE: tcnt_r <= EEPROM_WRITE_CYC; // R12
              `WAIT_FUSE: tcnt_r <= FUSE_WRITE_CYC; // R13
              `WAIT_ERASE: tcnt_r <= ERASE_CYC; // R13
              default: tcnt_r <= 32'h00000001;
            endcase
            bit_r <= 5'h00;
            div_r <= 8'h00;
            state_r <= S_FRAME;
          end
        end
        default:
          state_r <= S_OFF;
      endcase
    end
  end
endmodule // isp_host

//--- isp_host_asserts.sv
// Pin checker for the serial programming host.
`timescale 1ns/10ps
module isp_host_chk #(
  parameter [31:0] PWRUP_CYC = 32'd200
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic sck_o,
  input wire logic mosi_o,
  input wire logic reset_n_o,
  input wire logic done_o,
  input wire logic sync_fail_o
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  logic [31:0] low_r;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      low_r <= 32'h0;
    else if (reset_n_o)
      low_r <= 32'h0;
    else
      low_r <= low_r + 32'h1;
  end
  sequence s_hi4; sck_o [*4]; endsequence
  sequence s_lo4; !sck_o [*4]; endsequence
  property p_mosi; $changed(mosi_o) |-> !sck_o; endproperty
  property p_hi; $rose(sck_o) |-> s_hi4; endproperty
  property p_lo; $fell(sck_o) |-> s_lo4; endproperty
  property p_rst; reset_n_o |-> !sck_o; endproperty
  property p_pulse; $rose(reset_n_o) |-> reset_n_o [*2]; endproperty
  property p_wait; $rose(sck_o) |-> low_r >= PWRUP_CYC; endproperty
  property p_fail; sync_fail_o |=> sync_fail_o; endproperty
  property p_done; done_o |-> !sck_o; endproperty
  a_mosi: assert property (p_mosi)
    else $error("mosi moved with sck high");
  a_hi: assert property (p_hi)
    else $error("sck high too short");
  a_lo: assert property (p_lo)
    else $error("sck low too short");
  a_rst: assert property (p_rst)
    else $error("sck high with reset released");
  a_pulse: assert property (p_pulse)
    else $error("reset pulse too short");
  a_wait: assert property (p_wait)
    else $error("frame before power-up wait");
  a_fail: assert property (p_fail)
    else $error("sync fail flag dropped");
  a_done: assert property (p_done)
    else $error("done inside a frame");
endmodule // isp_host_chk
bind isp_host isp_host_chk #(.PWRUP_CYC(PWRUP_CYC)) u_chk (.clk_i(clk_i),
  .arst_n_i(arst_n_i), .sck_o(sck_o), .mosi_o(mosi_o),
  .reset_n_o(reset_n_o), .done_o(done_o), .sync_fail_o(sync_fail_o));

//--- isp_dev_model.sv
// Behavioural model of the device on the serial programming pins.
`timescale 1ns/10ps
module isp_dev_model #(
  parameter int BUSY_NS = 7500,
  parameter [31:0] SIG = 32'h11223344, // Arbitrary identity value.
  parameter [7:0] CAL = 8'h6b
) (
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic reset_n_i,
  input wire logic desync_i,
  output logic miso_o = 1'b0
);
  // ------------------------------------------------------------
  // Memories and frame decode
  // ------------------------------------------------------------
  logic [7:0] fl [0:8191];
  logic [7:0] ee [0:511];
  logic [7:0] pb [0:63];
  logic [31:0] sin = 32'h0;
  logic [7:0] rd = 8'h0, flo = 8'he1, fhi = 8'hd9;
  logic [5:0] lock = 6'h3f;
  logic [6:0] pg = 7'h0;
  logic en = 1'b0;
  int cnt = 0, i;
  realtime bend = 0;
  task wipe;
    for (i = 0; i < 8192; i++)
    begin
      fl[i] = 8'hff;
      ee[i % 512] = 8'hff;
      pb[i % 64] = 8'hff;
    end
  endtask
  initial wipe;
  always @(posedge sck_i or posedge reset_n_i)
  begin
    if (reset_n_i)
    begin
      cnt = 0;
      en = 1'b0;
    end
    else
    begin
      sin = {sin[30:0], mosi_i};
      cnt = cnt + 1;
      if (cnt == 24)
        case (sin[23:16])
          8'h20, 8'h28: rd = ($realtime < bend && pg == {sin[11:8], sin[7:5]})
            ? 8'hff : fl[{sin[11:8], sin[7:0], sin[19]}];
          8'ha0: rd = ($realtime < bend) ? 8'hff : ee[{sin[8], sin[7:0]}];
          8'h58: rd = sin[11] ? fhi : {2'b11, lock};
          8'h50: rd = flo;
          8'h30: rd = SIG[8 * sin[1:0] +: 8];
          8'h38: rd = CAL;
          default: rd = 8'h00;
        endcase
      if (cnt == 32)
      begin
        cnt = 0;
        if (sin[31:16] == 16'hac53)
          en = 1'b1;
        else if (en && sin[31:24] == 8'hac)
        begin
          if (sin[23:21] == 3'b100)
          begin
            wipe;
            bend = $realtime + BUSY_NS;
          end
          else if (sin[23:21] == 3'b111)
            lock = sin[5:0];
          else if (sin[23:16] == 8'ha0)
            flo = sin[7:0];
          else if (sin[23:16] == 8'ha8)
            fhi = sin[7:0];
        end
        else if (en && (sin[31:24] == 8'h40 || sin[31:24] == 8'h48))
          pb[{sin[12:8], sin[27]}] = sin[7:0];
        else if (en && sin[31:24] == 8'h4c)
        begin
          pg = {sin[19:16], sin[15:13]};
          for (i = 0; i < 64; i++)
            fl[{pg, i[5:0]}] = pb[i];
          bend = $realtime + BUSY_NS;
        end
        else if (en && sin[31:24] == 8'hc0)
        begin
          ee[{sin[16], sin[15:8]}] = sin[7:0];
          bend = $realtime + BUSY_NS;
        end
      end
    end
  end
  always @(negedge sck_i or posedge reset_n_i)
  begin
    if (reset_n_i || cnt < 8)
      miso_o = ~miso_o;
    else if (cnt >= 24)
      miso_o = rd[31 - cnt];
    else
      miso_o = sin[7] ^ desync_i;
  end
endmodule // isp_dev_model

//--- isp_host_tb_top.sv
// Self-checking bench for the serial programming host.
`timescale 1ns/10ps
module isp_host_tb_top;
  // ------------------------------------------------------------
  // Bench
  // ------------------------------------------------------------
  localparam [31:0] SIG = 32'h1e2d3c4b; // Arbitrary identity value.
  localparam [31:0] W = 32'd2000;
  logic clk_i, arst_n_i, ce_i, start_i, poll_i, enter_i, leave_i, desync;
  logic [7:0] op_i, b2_i, b3_i, b4_i;
  logic [2:0] wait_sel_i;
  wire sck_o, mosi_o, reset_n_o, busy_o, done_o, sync_ok_o, sync_fail_o;
  wire miso;
  wire [7:0] rdata_o;
  int miscompares = 0, comparisons = 0;
  isp_host #(.PWRUP_CYC(32'd200), .PAGE_WRITE_CYC(W), .FUSE_WRITE_CYC(W),
    .EEPROM_WRITE_CYC(W), .ERASE_CYC(W)) dut (.clk_i(clk_i),
    .arst_n_i(arst_n_i), .ce_i(ce_i), .start_i(start_i), .op_i(op_i),
    .b2_i(b2_i), .b3_i(b3_i), .b4_i(b4_i), .poll_i(poll_i),
    .wait_sel_i(wait_sel_i), .enter_i(enter_i), .leave_i(leave_i),
    .miso_i(miso), .sck_o(sck_o), .mosi_o(mosi_o), .reset_n_o(reset_n_o),
    .busy_o(busy_o), .done_o(done_o), .rdata_o(rdata_o),
    .sync_ok_o(sync_ok_o), .sync_fail_o(sync_fail_o));
  isp_dev_model #(.SIG(SIG)) dev (.sck_i(sck_o), .mosi_i(mosi_o),
    .reset_n_i(reset_n_o), .desync_i(desync), .miso_o(miso));
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  task wrap_up;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wt(input int s);
    logic [4:0] v;
    for (int n = 0; n < 20000; n++)
    begin
      @(posedge clk_i);
      v = {reset_n_o, sync_fail_o, sync_ok_o, done_o, busy_o};
      if (v[s] === 1'b1)
        return;
    end
    chk("wait", 8'h0, 8'h1);
    wrap_up;
  endtask
  task cmd(input [31:0] f, input logic p, input logic [2:0] w);
    @(posedge clk_i);
    {op_i, b2_i, b3_i, b4_i} <= f;
    poll_i <= p;
    wait_sel_i <= w;
    start_i <= 1'b1;
    wt(0);
    start_i <= 1'b0;
    wt(1);
  endtask
  task rdc(input string nm, input [31:0] f, input logic [7:0] exp);
    cmd(f, 1'b0, 3'h0);
    chk(nm, rdata_o, exp);
  endtask
  task t_sync;
    desync <= 1'b1;
    enter_i <= 1'b1;
    wt(3);
    desync <= 1'b0;
    wt(2);
    enter_i <= 1'b0;
    chk("fail", {7'h0, sync_fail_o}, 8'h1);
    $display("test sync done");
  endtask
  task t_ee;
    cmd(32'hc001a55a, 1'b1, 3'h2);
    rdc("ee", 32'ha001a500, 8'h5a);
    cmd(32'hc001a53c, 1'b1, 3'h2);
    rdc("ee", 32'ha001a500, 8'h3c);
    cmd(32'hc00007a6, 1'b0, 3'h0);
    rdc("ee busy", 32'ha0000700, 8'hff);
    rdc("ee", 32'ha0000700, 8'ha6);
    $display("test eeprom done");
  endtask
  task t_flash;
    cmd(32'h40000312, 1'b0, 3'h0);
    cmd(32'h48000334, 1'b0, 3'h0);
    cmd(32'h4c02a000, 1'b0, 3'h0);
    rdc("fl busy", 32'h2002a300, 8'hff);
    rdc("fl lo", 32'h2002a300, 8'h12);
    rdc("fl hi", 32'h2802a300, 8'h34);
    rdc("fl page", 32'h20028300, 8'hff);
    cmd(32'h40000456, 1'b0, 3'h0);
    cmd(32'h4c02a000, 1'b0, 3'h1);
    rdc("fl", 32'h2002a400, 8'h56);
    cmd(32'h40000078, 1'b0, 3'h0);
    cmd(32'h4c02a078, 1'b1, 3'h1);
    rdc("fl poll", 32'h2002a000, 8'h78);
    $display("test flash done");
  endtask
  task t_cfg;
    cmd(32'haca000e4, 1'b0, 3'h3);
    cmd(32'haca800c9, 1'b0, 3'h3);
    cmd(32'hace000fc, 1'b0, 3'h3);
    rdc("fuse lo", 32'h50000000, 8'he4);
    rdc("fuse hi", 32'h58080000, 8'hc9);
    rdc("lock", 32'h58000000, 8'hfc);
    for (int k = 0; k < 4; k++)
      rdc("sig", {16'h3000, 6'h0, k[1:0], 8'h00}, SIG[8 * k +: 8]);
    rdc("cal", 32'h38000000, 8'h6b);
    $display("test config done");
  endtask
  task t_ce;
    logic [2:0] held;
    fork
      rdc("ce cal", 32'h38000000, 8'h6b);
      begin
        repeat (300) @(posedge clk_i);
        ce_i <= 1'b0;
        @(posedge clk_i);
        held = {sck_o, mosi_o, busy_o};
        repeat (40) @(posedge clk_i);
        chk("ce hold", {5'h0, sck_o, mosi_o, busy_o}, {5'h0, held});
        ce_i <= 1'b1;
      end
    join
    $display("test clock enable done");
  endtask
  task t_erase;
    cmd(32'hac800000, 1'b0, 3'h4);
    rdc("erase fl", 32'h2802a300, 8'hff);
    rdc("erase ee", 32'ha001a500, 8'hff);
    leave_i <= 1'b1;
    wt(4);
    leave_i <= 1'b0;
    chk("reset", {7'h0, reset_n_o}, 8'h1);
    $display("test erase done");
  endtask
  initial
  begin
    arst_n_i = 1'b0;
    {start_i, poll_i, enter_i, leave_i, desync} = 5'h0;
    {op_i, b2_i, b3_i, b4_i} = 32'h0;
    wait_sel_i = 3'h0;
    ce_i = 1'b1;
    repeat (16) @(posedge clk_i);
    arst_n_i <= 1'b1;
    t_sync;
    t_ee;
    t_flash;
    t_cfg;
    t_ce;
    t_erase;
    wrap_up;
  end
endmodule // isp_host_tb_top
